// ---- rtl/alarm_sup_cfg.svh ----
`ifndef ALARM_SUP_CFG_SVH
`define ALARM_SUP_CFG_SVH
// register byte offsets
`define OFS_STATUS     8'h00
`define OFS_MASK       8'h04
`define OFS_LIVE       8'h08
`define OFS_CTRL       8'h0C
`define OFS_TEMP_HI    8'h10
`define OFS_TEMP_LO    8'h14
`define OFS_FLOW_MIN   8'h18
`define OFS_SCAT_MAX   8'h1C
`define OFS_PWR_SET    8'h20
`define OFS_MEAS       8'h24
// alarm bit positions
`define BIT_TEMP_HI    0
`define BIT_TEMP_LO    1
`define BIT_FLOW       2
`define BIT_SCAT       3
`define BIT_PWR        4
`define BIT_PSU        5
`define BIT_COND       6
`define BIT_ILOCK      7
`define NUM_ALARM      8
// reset values
`define RST_TEMP_HI    12'hFFF
`define RST_TEMP_LO    12'h000
`define RST_FLOW_MIN   12'h000
`define RST_SCAT_MAX   12'hFFF
`define RST_PWR_SET    12'h000
`define RST_MASK       8'h00
// measurement width
`define MEAS_W         12
// status-side: live bits sit in bits 8 to 11 of live register, above the latched alarm byte
`define LIVE_LOCK_BIT  8
`define LIVE_PERM_BIT  9
`define LIVE_EMIT_BIT  10
`define LIVE_RDY_BIT   11
// synchroniser reset levels: interlock idles normal, request idles off
`define RST_ILOCK_OK   1'b1
`define RST_EMIT_REQ   1'b0
// byte lanes of the bus
`define LANE0_MSB      7
`define LANE1_LSB      8
`endif

// ---- rtl/alarm_sup_pkg.sv ----
package alarm_sup_pkg;
	typedef logic [7:0] alarm_vec_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EMIT = 2'b01,
		ST_LOCK = 2'b11
	} emit_state_e;
endpackage

// ---- rtl/laser_alarm_supervisor.sv ----
`timescale 1ns/1ps
`include "alarm_sup_cfg.svh"
module laser_alarm_supervisor (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// wishbone slave
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [7:0]            adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	// sensors, sampled from pins
	input  wire logic [`MEAS_W-1:0]    temp_i,
	input  wire logic [`MEAS_W-1:0]    flow_i,
	input  wire logic [`MEAS_W-1:0]    scatter_i,
	input  wire logic [`MEAS_W-1:0]    power_i,
	input  wire logic                  psu_fault_i,
	input  wire logic                  cond_fault_i,
	input  wire logic                  interlock_ok_i,
	input  wire logic                  emit_req_i,
	// outputs
	output logic                       emit_o,
	output logic                       ready_o,
	output logic                       alarm_lamp_o,
	output logic                       irq_o
);

	localparam int W = `MEAS_W;

	// two-stage synchronisers for all pin inputs
	// interlock resets to normal: a zero here would log a false interlock event at release
	localparam logic [4*W+3:0] SYNC_IDLE = {{(4*W+2){1'b0}}, `RST_ILOCK_OK, `RST_EMIT_REQ};
	logic [4*W+3:0] pin_raw;
	logic [4*W+3:0] sync1_q;
	logic [4*W+3:0] sync2_q;
	assign pin_raw = {temp_i, flow_i, scatter_i, power_i,
		psu_fault_i, cond_fault_i, interlock_ok_i, emit_req_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= SYNC_IDLE;
			sync2_q <= SYNC_IDLE;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end

	// sampled values; multi-bit words may tear for one cycle, harmless for threshold checks
	logic [W-1:0] temp_s;
	logic [W-1:0] flow_s;
	logic [W-1:0] scat_s;
	logic [W-1:0] pwr_s;
	logic         psu_s;
	logic         cond_s;
	logic         ilock_ok_s;
	logic         req_s;
	assign {temp_s, flow_s, scat_s, pwr_s, psu_s, cond_s, ilock_ok_s, req_s} = sync2_q;

	// configuration registers
	logic [W-1:0]                temp_hi_q;
	logic [W-1:0]                temp_hi_d;
	logic [W-1:0]                temp_lo_q;
	logic [W-1:0]                temp_lo_d;
	logic [W-1:0]                flow_min_q;
	logic [W-1:0]                flow_min_d;
	logic [W-1:0]                scat_max_q;
	logic [W-1:0]                scat_max_d;
	logic [W-1:0]                pwr_set_q;
	logic [W-1:0]                pwr_set_d;
	alarm_sup_pkg::alarm_vec_t   mask_q;
	alarm_sup_pkg::alarm_vec_t   mask_d;
	alarm_sup_pkg::alarm_vec_t   status_q;
	alarm_sup_pkg::alarm_vec_t   status_d;
	alarm_sup_pkg::alarm_vec_t   latch_q;
	alarm_sup_pkg::alarm_vec_t   latch_d;
	alarm_sup_pkg::emit_state_e  state_q;
	alarm_sup_pkg::emit_state_e  state_d;
	logic                        perm_q;
	logic                        perm_d;
	logic                        emit_q;
	logic                        emit_d;
	logic                        ready_q;
	logic                        ready_d;
	logic                        lamp_q;
	logic                        lamp_d;
	logic                        irq_q;
	logic                        irq_d;
	logic                        ack_q;
	logic                        ack_d;
	logic [31:0]                 rdata_q;
	logic [31:0]                 rdata_d;

	// raw fault conditions
	alarm_sup_pkg::alarm_vec_t cond_v;
	logic emitting;
	logic fault_any;
	assign emitting = (state_q == alarm_sup_pkg::ST_EMIT);

	always_comb begin
		cond_v                = '0;
		cond_v[`BIT_TEMP_HI]  = temp_s > temp_hi_q;
		cond_v[`BIT_TEMP_LO]  = temp_s < temp_lo_q;
		cond_v[`BIT_FLOW]     = flow_s < flow_min_q;
		cond_v[`BIT_SCAT]     = emitting && (scat_s > scat_max_q);
		cond_v[`BIT_PWR]      = emitting && (pwr_s < pwr_set_q);
		cond_v[`BIT_PSU]      = psu_s;
		cond_v[`BIT_COND]     = cond_s;
		cond_v[`BIT_ILOCK]    = !ilock_ok_s;
	end

	// interlock excluded: it never locks or lights the lamp
	assign fault_any = |cond_v[`BIT_COND:`BIT_TEMP_HI];

	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	assign bus_req = cyc_i && stb_i && !ack_q;
	assign bus_wr  = bus_req && we_i;
	assign bus_rd  = bus_req && !we_i;

	// write-enable for a 12-bit threshold, honouring byte lanes
	function automatic logic [W-1:0] lane_wr(
		input logic [W-1:0] cur,
		input logic [31:0]  d,
		input logic [3:0]   s
	);
		logic [W-1:0] r;
		r = cur;
		if (s[0]) begin
			r[`LANE0_MSB:0] = d[`LANE0_MSB:0];
		end
		if (s[1]) begin
			r[W-1:`LANE1_LSB] = d[W-1:`LANE1_LSB];
		end
		return r;
	endfunction

	// register file and alarm latching
	always_comb begin
		temp_hi_d  = temp_hi_q;
		temp_lo_d  = temp_lo_q;
		flow_min_d = flow_min_q;
		scat_max_d = scat_max_q;
		pwr_set_d  = pwr_set_q;
		mask_d     = mask_q;
		status_d   = status_q;
		latch_d    = latch_q | cond_v;
		if (bus_wr) begin
			unique case (adr_i)
				`OFS_STATUS: begin
					if (sel_i[0]) status_d = status_q & ~dat_i[`NUM_ALARM-1:0];
				end
				`OFS_MASK: begin
					if (sel_i[0]) mask_d = dat_i[`NUM_ALARM-1:0];
				end
				`OFS_TEMP_HI:  temp_hi_d  = lane_wr(temp_hi_q, dat_i, sel_i);
				`OFS_TEMP_LO:  temp_lo_d  = lane_wr(temp_lo_q, dat_i, sel_i);
				`OFS_FLOW_MIN: flow_min_d = lane_wr(flow_min_q, dat_i, sel_i);
				`OFS_SCAT_MAX: scat_max_d = lane_wr(scat_max_q, dat_i, sel_i);
				`OFS_PWR_SET:  pwr_set_d  = lane_wr(pwr_set_q, dat_i, sel_i);
				default: ;
			endcase
		end
		// new events win over a same-cycle write-one-to-clear
		status_d = status_d | (cond_v & ~latch_q);
	end

	// emission state: lock is only left through reset
	always_comb begin
		state_d = state_q;
		perm_d  = perm_q | cond_v[`BIT_SCAT];
		unique case (state_q)
			alarm_sup_pkg::ST_IDLE: begin
				if (fault_any) state_d = alarm_sup_pkg::ST_LOCK;
				else if (req_s && ilock_ok_s) state_d = alarm_sup_pkg::ST_EMIT;
			end
			alarm_sup_pkg::ST_EMIT: begin
				if (fault_any) state_d = alarm_sup_pkg::ST_LOCK;
				else if (!req_s || !ilock_ok_s) state_d = alarm_sup_pkg::ST_IDLE;
			end
			alarm_sup_pkg::ST_LOCK: state_d = alarm_sup_pkg::ST_LOCK;
			default: state_d = alarm_sup_pkg::ST_LOCK;
		endcase
		// fault takes emission down in the same edge as entering lock
		emit_d  = (state_d == alarm_sup_pkg::ST_EMIT);
	end

	// indicators; ready ignores the lock so the host still sees interlock state
	always_comb begin
		ready_d = ilock_ok_s;
		lamp_d  = lamp_q | fault_any;
		irq_d   = |(status_d & mask_d);
	end

	// read mux and ack, one wait-free cycle
	always_comb begin
		ack_d   = bus_req;
		rdata_d = '0;
		if (bus_rd) begin
			unique case (adr_i)
				`OFS_STATUS:   rdata_d[`NUM_ALARM-1:0] = status_q;
				`OFS_MASK:     rdata_d[`NUM_ALARM-1:0] = mask_q;
				`OFS_LIVE: begin
					rdata_d[`NUM_ALARM-1:0] = latch_q;
					rdata_d[`LIVE_LOCK_BIT] = (state_q == alarm_sup_pkg::ST_LOCK);
					rdata_d[`LIVE_PERM_BIT] = perm_q;
					rdata_d[`LIVE_EMIT_BIT] = emitting;
					rdata_d[`LIVE_RDY_BIT]  = ready_q;
				end
				`OFS_CTRL:     rdata_d[`NUM_ALARM-1:0] = cond_v;
				`OFS_TEMP_HI:  rdata_d[W-1:0] = temp_hi_q;
				`OFS_TEMP_LO:  rdata_d[W-1:0] = temp_lo_q;
				`OFS_FLOW_MIN: rdata_d[W-1:0] = flow_min_q;
				`OFS_SCAT_MAX: rdata_d[W-1:0] = scat_max_q;
				`OFS_PWR_SET:  rdata_d[W-1:0] = pwr_set_q;
				`OFS_MEAS:     rdata_d[W-1:0] = pwr_s;
				default:       rdata_d = '0;
			endcase
		end
	end

	// configuration and alarm flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			temp_hi_q  <= `RST_TEMP_HI;
			temp_lo_q  <= `RST_TEMP_LO;
			flow_min_q <= `RST_FLOW_MIN;
			scat_max_q <= `RST_SCAT_MAX;
			pwr_set_q  <= `RST_PWR_SET;
			mask_q     <= `RST_MASK;
			status_q   <= '0;
			latch_q    <= '0;
		end else begin
			temp_hi_q  <= temp_hi_d;
			temp_lo_q  <= temp_lo_d;
			flow_min_q <= flow_min_d;
			scat_max_q <= scat_max_d;
			pwr_set_q  <= pwr_set_d;
			mask_q     <= mask_d;
			status_q   <= status_d;
			latch_q    <= latch_d;
		end
	end

	// emission state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q    <= alarm_sup_pkg::ST_IDLE;
			perm_q     <= 1'b0;
			emit_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			perm_q     <= perm_d;
			emit_q     <= emit_d;
		end
	end

	// indicators
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_q    <= 1'b0;
			lamp_q     <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			ready_q    <= ready_d;
			lamp_q     <= lamp_d;
			irq_q      <= irq_d;
		end
	end

	// bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q      <= 1'b0;
			rdata_q    <= '0;
		end else begin
			ack_q      <= ack_d;
			rdata_q    <= rdata_d;
		end
	end

	assign emit_o       = emit_q;
	assign ready_o      = ready_q;
	assign alarm_lamp_o = lamp_q;
	assign irq_o        = irq_q;
	assign ack_o        = ack_q;
	assign dat_o        = rdata_q;

endmodule

// ---- sim/laser_alarm_supervisor_properties.sv ----
`timescale 1ns/1ps
module laser_alarm_supervisor_properties (
	// watched ports
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        psu_fault_i,
	input wire logic        interlock_ok_i,
	input wire logic        emit_o,
	input wire logic        ready_o,
	input wire logic        alarm_lamp_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bus request not acked");
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
	property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	property p_lamp_hold; alarm_lamp_o |=> alarm_lamp_o; endproperty
	a_lamp_hold: assert property (p_lamp_hold) else $error("lamp cleared");
	property p_lock_stop; alarm_lamp_o |-> !emit_o; endproperty
	a_lock_stop: assert property (p_lock_stop) else $error("emission while locked");
	property p_psu_lamp; psu_fault_i |-> ##3 alarm_lamp_o; endproperty
	a_psu_lamp: assert property (p_psu_lamp) else $error("supply fault not lit");
	property p_ready_hi; interlock_ok_i [*3] |=> ready_o; endproperty
	a_ready_hi: assert property (p_ready_hi) else $error("ready low");
	property p_ready_lo; !interlock_ok_i [*3] |=> !ready_o; endproperty
	a_ready_lo: assert property (p_ready_lo) else $error("ready high");
endmodule

// ---- sim/host_ctrl_model.sv ----
`timescale 1ns/1ps
module host_ctrl_model (
	input  wire logic ready_i,
	input  wire logic want_i,
	output logic      emit_req_o
);
	// a fallen ready withdraws the request at once
	assign emit_req_o = want_i & ready_i;
endmodule

// ---- sim/laser_alarm_supervisor_tb_top.sv ----
`timescale 1ns/1ps
`include "alarm_sup_cfg.svh"
module laser_alarm_supervisor_tb_top;
	logic        clk_i, rst_i, cyc, stb, we, psu, cond, ilk, want, emit_req;
	logic        ack_o, emit_o, ready_o, lamp, irq;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, dat_o, rd, e, seed;
	logic [11:0] temp, flow, scat, pwr, v;
	int          n_errors, check_count, cyc_n;
	logic [7:0]  ofs [7] = '{`OFS_TEMP_HI, `OFS_TEMP_LO, `OFS_FLOW_MIN, `OFS_SCAT_MAX,
		`OFS_PWR_SET, `OFS_MASK, 8'h30};
	logic [31:0] rv [7] = '{32'(`RST_TEMP_HI), 32'(`RST_TEMP_LO), 32'(`RST_FLOW_MIN),
		32'(`RST_SCAT_MAX), 32'(`RST_PWR_SET), 32'(`RST_MASK), 32'h0};
	laser_alarm_supervisor dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.temp_i(temp), .flow_i(flow), .scatter_i(scat), .power_i(pwr), .psu_fault_i(psu),
		.cond_fault_i(cond), .interlock_ok_i(ilk), .emit_req_i(emit_req), .emit_o(emit_o),
		.ready_o(ready_o), .alarm_lamp_o(lamp), .irq_o(irq));
	host_ctrl_model host_u (.ready_i(ready_o), .want_i(want), .emit_req_o(emit_req));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic calm(input logic w);
		{psu, cond, want} <= {2'b00, w};
		ilk <= 1'b1;
		temp <= 12'h800;
		flow <= 12'h800;
		scat <= 12'h000;
		pwr <= 12'hFFF;
	endtask
	task automatic rst_run;
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		{cyc, stb, we, psu, cond, want, rst_i} = 7'h01;
		{adr, sel, dat} = '0;
		{ilk, temp, flow, scat, pwr} = {1'b1, 12'h800, 12'h800, 12'h000, 12'hFFF};
		seed = 32'h292B;
		@(posedge clk_i);
		rst_run();
		for (int i = 0; i < 7; i++) begin
			wb(1'b0, ofs[i], 32'h0);
			chk("reset value", rd, rv[i]);
		end
		want <= 1'b1;
		repeat (4) @(posedge clk_i);
		wb(1'b0, `OFS_LIVE, 32'h0);
		chk("live emitting", rd & 32'hFFF, 32'hC00);
		ilk <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk("ready", ready_o, 1'b0);
		chk("emit", emit_o, 1'b0);
		chk("lamp", lamp, 1'b0);
		wb(1'b1, `OFS_MASK, 32'h80);
		repeat (2) @(posedge clk_i);
		chk("irq set", irq, 1'b1);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk("status", rd & 32'hFF, 32'h80);
		calm(1'b0);
		repeat (6) @(posedge clk_i);
		wb(1'b1, `OFS_STATUS, 32'h80);
		repeat (2) @(posedge clk_i);
		chk("irq clear", irq, 1'b0);
		chk("ready back", ready_o, 1'b1);
		for (int b = 0; b < 7; b++) begin
			logic lo;
			seed = xs(seed);
			v = 12'h800 + seed[9:0];
			lo = !(b == 0 || b == 3);
			calm(1'b0);
			rst_run();
			if (b < 5)
				wb(1'b1, ofs[b], lo ? v - 12'h400 : v);
			case (b)
				0: temp <= v + 12'h1;
				1: temp <= v - 12'h401;
				2: flow <= v - 12'h401;
				3: scat <= v + 12'h1;
				4: pwr <= v - 12'h401;
				5: psu <= 1'b1;
				default: cond <= 1'b1;
			endcase
			repeat (6) @(posedge clk_i);
			e = (b == 3 || b == 4) ? 32'h800 : 32'h900 | (32'h1 << b);
			wb(1'b0, `OFS_LIVE, 32'h0);
			chk("live idle", rd & 32'hFFF, e);
			want <= 1'b1;
			repeat (8) @(posedge clk_i);
			e = 32'h900 | (32'h1 << b) | (b == 3 ? 32'h200 : 32'h0);
			wb(1'b0, `OFS_LIVE, 32'h0);
			chk("live run", rd & 32'hFFF, e);
			chk("lamp on", lamp, 1'b1);
			calm(1'b1);
			repeat (6) @(posedge clk_i);
			chk("lamp held", lamp, 1'b1);
			chk("still locked", emit_o, 1'b0);
			wb(1'b0, `OFS_STATUS, 32'h0);
			chk("status bit", rd & 32'hFF, 32'h1 << b);
		end
		end_of_test();
	end
endmodule
bind laser_alarm_supervisor laser_alarm_supervisor_properties chk_u (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
	.psu_fault_i(psu_fault_i), .interlock_ok_i(interlock_ok_i), .emit_o(emit_o),
	.ready_o(ready_o), .alarm_lamp_o(alarm_lamp_o));
